// [pad_mux_pkg.sv]
// Constants and helper functions shared by the pad multiplexer files
package pad_mux_pkg;
    localparam int NUM_PADS = 8;
    localparam int NUM_FUNCS = 7;
    localparam int PORT_PINS = 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int MODE_W = 3;
    localparam int CFG_W = 6;
    localparam int SYNC_STAGES = 3;

    localparam logic [MODE_W-1:0] MODE_PRIMARY = 3'h0;
    localparam logic [MODE_W-1:0] MODE_ALT3 = 3'h3;
    localparam logic [MODE_W-1:0] MODE_GPIO = 3'h5;
    localparam logic [MODE_W-1:0] MODE_LAST = 3'h6;

    localparam int SEL_LOOPBACK_BIT = 4;
    localparam int CFG_SLEW_BIT = 0;
    localparam int CFG_DRIVE_LSB = 1;
    localparam int CFG_DRIVE_W = 3;
    localparam int CFG_PULL_LSB = 4;
    localparam int CFG_PULL_W = 2;
    localparam int OUTSRC_PINS_PER_REG = 16;

    localparam logic [ADDR_W-1:0] FUNC_SEL_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] PAD_CFG_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] INPUT_SEL_OFS = 8'h40;
    localparam logic [ADDR_W-1:0] PAD_GPIO_DATA_OFS = 8'h44;
    localparam logic [ADDR_W-1:0] PAD_GPIO_DIR_OFS = 8'h48;
    localparam logic [ADDR_W-1:0] PAD_LEVEL_OFS = 8'h4c;
    localparam logic [ADDR_W-1:0] IN_USE_OFS = 8'h50;
    localparam logic [ADDR_W-1:0] PULLUP_OFS = 8'h54;
    localparam logic [ADDR_W-1:0] PORT_DATA_OFS = 8'h58;
    localparam logic [ADDR_W-1:0] PORT_DIR_OFS = 8'h5c;
    localparam logic [ADDR_W-1:0] PORT_LEVEL_OFS = 8'h60;
    localparam logic [ADDR_W-1:0] OUTSRC_LO_OFS = 8'h64;
    localparam logic [ADDR_W-1:0] OUTSRC_HI_OFS = 8'h68;
    localparam logic [ADDR_W-1:0] IN_ROUTE_OFS = 8'h6c;
    localparam logic [ADDR_W-1:0] FIXED_MASK_OFS = 8'h70;

    localparam logic [CFG_W-1:0] PAD_CFG_RESET = 6'h04;
    localparam logic [NUM_PADS-1:0] FIXED_PAD_MASK = 8'h01;
    localparam logic [NUM_PADS*MODE_W-1:0] FIXED_PAD_MODE = 24'h000000;

    localparam logic [1:0] OUTSRC_DATA = 2'h0;
    localparam logic [1:0] OUTSRC_A = 2'h1;
    localparam logic [1:0] OUTSRC_B = 2'h2;
    localparam logic [1:0] OUTSRC_C = 2'h3;

    function automatic logic inBank(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] base);
        return addr[1:0] == 2'h0 && addr >= base
            && addr < base + ADDR_W'(4 * NUM_PADS);
    endfunction

    function automatic logic [2:0] bankIndex(input logic [ADDR_W-1:0] addr,
                                             input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] diff;
        diff = addr - base;
        return diff[4:2];
    endfunction
endpackage

// [pad_input_sync.sv]
// Three-stage input synchroniser that accepts a change once stages two and three agree
module pad_input_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Raw and filtered levels
    input wire logic [W-1:0] rawIn,
    output logic [W-1:0] level
);
    logic [W-1:0] s1Q;
    logic [W-1:0] s2Q;
    logic [W-1:0] s3Q;
    logic [W-1:0] levelQ;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s1Q <= '0;
            s2Q <= '0;
            s3Q <= '0;
        end else begin
            s1Q <= rawIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
        end
    end

    // Bits where the later stages disagree keep their previous level
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            levelQ <= '0;
        end else begin
            levelQ <= (s2Q & ~(s2Q ^ s3Q)) | (levelQ & (s2Q ^ s3Q));
        end
    end

    assign level = levelQ;
endmodule

// [pad_route_cell.sv]
// Per-pad output selection from the function select code
module pad_route_cell (
    // Selection
    input wire logic [pad_mux_pkg::MODE_W-1:0] mode,
    // Candidate drivers, index equals mode
    input wire logic [pad_mux_pkg::NUM_FUNCS-1:0] funcOut,
    input wire logic [pad_mux_pkg::NUM_FUNCS-1:0] funcOe,
    // Software-driven general-purpose bit
    input wire logic gpioData,
    input wire logic gpioDir,
    // Next pad drive
    output logic outD,
    output logic oeD
);
    always_comb begin
        outD = 1'b0;
        oeD = 1'b0;
        if (mode == pad_mux_pkg::MODE_GPIO) begin
            outD = gpioData;
            oeD = gpioDir;
        end else if (mode <= pad_mux_pkg::MODE_LAST) begin
            outD = funcOut[mode];
            oeD = funcOe[mode];
        end
    end
endmodule

// [pad_function_multiplexer.sv]
// Pad function multiplexer with pad configuration and a GPIO-controlled port
//
// Contract
// - Each pad: peripheral-driven or software GPIO
// - Primary or numbered alternate function selectable
// - Mode codes 0 to 6 route their own signal, except code 5, which routes the GPIO bit; code 7 drives nothing
// - Integration-fixed pads ignore function select writes
// - Function select also enables pad loopback
// - Input select picks pad feeding port
// - Pad setting drives slew, strength, pull
// - 32-bit in-use selects peripheral or GPIO
// - Per-pin pull-up enable register per port
// - GPIO special output sources, input routes
// - GPIO output level from register bit
// - GPIO input level readable by software
module pad_function_multiplexer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire logic [pad_mux_pkg::ADDR_W-1:0] regAddr,
    input wire logic [pad_mux_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [pad_mux_pkg::DATA_W-1:0] regRdata,
    // Multiplexed pads
    input wire logic [pad_mux_pkg::NUM_PADS-1:0] padIn,
    output logic [pad_mux_pkg::NUM_PADS-1:0] padOut,
    output logic [pad_mux_pkg::NUM_PADS-1:0] padOe,
    output logic [pad_mux_pkg::NUM_PADS-1:0] padSlew,
    output logic [pad_mux_pkg::NUM_PADS*pad_mux_pkg::CFG_DRIVE_W-1:0] padDrive,
    output logic [pad_mux_pkg::NUM_PADS*pad_mux_pkg::CFG_PULL_W-1:0] padPull,
    // Peripheral side of multiplexed pads
    input wire logic [pad_mux_pkg::NUM_PADS*pad_mux_pkg::NUM_FUNCS-1:0] periphPadOut,
    input wire logic [pad_mux_pkg::NUM_PADS*pad_mux_pkg::NUM_FUNCS-1:0] periphPadOe,
    output logic [pad_mux_pkg::NUM_PADS-1:0] periphPadIn,
    output logic muxedPortIn,
    // GPIO-controlled port pins
    input wire logic [pad_mux_pkg::PORT_PINS-1:0] portPadIn,
    output logic [pad_mux_pkg::PORT_PINS-1:0] portPadOut,
    output logic [pad_mux_pkg::PORT_PINS-1:0] portPadOe,
    output logic [pad_mux_pkg::PORT_PINS-1:0] portPullup,
    // Peripheral side of port pins
    input wire logic [pad_mux_pkg::PORT_PINS-1:0] portPeriphOut,
    input wire logic [pad_mux_pkg::PORT_PINS-1:0] portPeriphOe,
    input wire logic [pad_mux_pkg::PORT_PINS-1:0] portSigA,
    input wire logic [pad_mux_pkg::PORT_PINS-1:0] portSigB,
    input wire logic [pad_mux_pkg::PORT_PINS-1:0] portSigC,
    output logic [pad_mux_pkg::PORT_PINS-1:0] portPeriphIn,
    output logic [pad_mux_pkg::PORT_PINS-1:0] portRouteA,
    output logic [pad_mux_pkg::PORT_PINS-1:0] portRouteB
);
    localparam int NP = pad_mux_pkg::NUM_PADS;
    localparam int NF = pad_mux_pkg::NUM_FUNCS;
    localparam int PP = pad_mux_pkg::PORT_PINS;
    localparam int MW = pad_mux_pkg::MODE_W;
    localparam int CW = pad_mux_pkg::CFG_W;

    logic [MW-1:0] funcSelQ [NP];
    logic [NP-1:0] loopbackQ;
    logic [CW-1:0] padCfgQ [NP];
    logic [2:0] inputSelQ;
    logic [NP-1:0] padGpioDataQ;
    logic [NP-1:0] padGpioDirQ;
    logic [PP-1:0] inUseQ;
    logic [PP-1:0] pullupQ;
    logic [PP-1:0] portDataQ;
    logic [PP-1:0] portDirQ;
    logic [2*PP-1:0] outSrcQ;
    logic [PP-1:0] inRouteQ;
    logic [pad_mux_pkg::DATA_W-1:0] rdataQ;
    logic [NP-1:0] padLevel;
    logic [PP-1:0] portLevel;
    logic [NP-1:0] padOutD;
    logic [NP-1:0] padOeD;
    logic [NP-1:0] padOutQ;
    logic [NP-1:0] padOeQ;
    logic [PP-1:0] portOutD;
    logic [PP-1:0] portOeD;
    logic [PP-1:0] portOutQ;
    logic [PP-1:0] portOeQ;
    logic [PP-1:0] portPeriphInQ;
    logic [PP-1:0] routeAQ;
    logic [PP-1:0] routeBQ;
    logic [NP-1:0] periphPadInQ;
    logic muxedPortInQ;
    logic [NP-1:0] slewQ;
    logic [NP*pad_mux_pkg::CFG_DRIVE_W-1:0] driveQ;
    logic [NP*pad_mux_pkg::CFG_PULL_W-1:0] pullQ;
    logic [PP-1:0] pullupOutQ;
    logic [2:0] wrIdx;
    logic [2:0] rdIdx;

    // Pad levels come from outside the clock domain
    pad_input_sync #(.W(NP)) padSync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rawIn(padIn),
        .level(padLevel)
    );

    pad_input_sync #(.W(PP)) portSync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rawIn(portPadIn),
        .level(portLevel)
    );

    assign wrIdx = pad_mux_pkg::bankIndex(regAddr, pad_mux_pkg::FUNC_SEL_BASE);
    assign rdIdx = pad_mux_pkg::bankIndex(regAddr, pad_mux_pkg::PAD_CFG_BASE);

    // Function select; hard-wired pads keep their integration mode
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NP; i++) begin
                funcSelQ[i] <= pad_mux_pkg::MODE_PRIMARY;
            end
            loopbackQ <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (pad_mux_pkg::FIXED_PAD_MASK[i]) begin
                    funcSelQ[i] <= pad_mux_pkg::FIXED_PAD_MODE[i*MW +: MW];
                    loopbackQ[i] <= 1'b0;
                end else if (regWr && wrIdx == 3'(i)
                             && pad_mux_pkg::inBank(regAddr, pad_mux_pkg::FUNC_SEL_BASE)) begin
                    funcSelQ[i] <= regWdata[MW-1:0];
                    loopbackQ[i] <= regWdata[pad_mux_pkg::SEL_LOOPBACK_BIT];
                end
            end
        end
    end

    // Electrical pad settings
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NP; i++) begin
                padCfgQ[i] <= pad_mux_pkg::PAD_CFG_RESET;
            end
        end else if (regWr && pad_mux_pkg::inBank(regAddr, pad_mux_pkg::PAD_CFG_BASE)) begin
            padCfgQ[rdIdx] <= regWdata[CW-1:0];
        end
    end

    // Single-word control registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            inputSelQ <= '0;
            padGpioDataQ <= '0;
            padGpioDirQ <= '0;
            inUseQ <= '0;
            pullupQ <= '0;
            portDataQ <= '0;
            portDirQ <= '0;
            outSrcQ <= '0;
            inRouteQ <= '0;
        end else if (regWr) begin
            if (regAddr == pad_mux_pkg::INPUT_SEL_OFS) begin
                inputSelQ <= regWdata[2:0];
            end else if (regAddr == pad_mux_pkg::PAD_GPIO_DATA_OFS) begin
                padGpioDataQ <= regWdata[NP-1:0];
            end else if (regAddr == pad_mux_pkg::PAD_GPIO_DIR_OFS) begin
                padGpioDirQ <= regWdata[NP-1:0];
            end else if (regAddr == pad_mux_pkg::IN_USE_OFS) begin
                inUseQ <= regWdata;
            end else if (regAddr == pad_mux_pkg::PULLUP_OFS) begin
                pullupQ <= regWdata;
            end else if (regAddr == pad_mux_pkg::PORT_DATA_OFS) begin
                portDataQ <= regWdata;
            end else if (regAddr == pad_mux_pkg::PORT_DIR_OFS) begin
                portDirQ <= regWdata;
            end else if (regAddr == pad_mux_pkg::OUTSRC_LO_OFS) begin
                outSrcQ[PP-1:0] <= regWdata;
            end else if (regAddr == pad_mux_pkg::OUTSRC_HI_OFS) begin
                outSrcQ[2*PP-1:PP] <= regWdata;
            end else if (regAddr == pad_mux_pkg::IN_ROUTE_OFS) begin
                inRouteQ <= regWdata;
            end
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdataQ <= '0;
        end else if (!regRd) begin
            rdataQ <= '0;
        end else if (pad_mux_pkg::inBank(regAddr, pad_mux_pkg::FUNC_SEL_BASE)) begin
            rdataQ <= {27'h0, loopbackQ[wrIdx], 1'b0, funcSelQ[wrIdx]};
        end else if (pad_mux_pkg::inBank(regAddr, pad_mux_pkg::PAD_CFG_BASE)) begin
            rdataQ <= {26'h0, padCfgQ[rdIdx]};
        end else if (regAddr == pad_mux_pkg::INPUT_SEL_OFS) begin
            rdataQ <= {29'h0, inputSelQ};
        end else if (regAddr == pad_mux_pkg::PAD_GPIO_DATA_OFS) begin
            rdataQ <= {24'h0, padGpioDataQ};
        end else if (regAddr == pad_mux_pkg::PAD_GPIO_DIR_OFS) begin
            rdataQ <= {24'h0, padGpioDirQ};
        end else if (regAddr == pad_mux_pkg::PAD_LEVEL_OFS) begin
            rdataQ <= {24'h0, padLevel};
        end else if (regAddr == pad_mux_pkg::IN_USE_OFS) begin
            rdataQ <= inUseQ;
        end else if (regAddr == pad_mux_pkg::PULLUP_OFS) begin
            rdataQ <= pullupQ;
        end else if (regAddr == pad_mux_pkg::PORT_DATA_OFS) begin
            rdataQ <= portDataQ;
        end else if (regAddr == pad_mux_pkg::PORT_DIR_OFS) begin
            rdataQ <= portDirQ;
        end else if (regAddr == pad_mux_pkg::PORT_LEVEL_OFS) begin
            rdataQ <= portLevel;
        end else if (regAddr == pad_mux_pkg::OUTSRC_LO_OFS) begin
            rdataQ <= outSrcQ[PP-1:0];
        end else if (regAddr == pad_mux_pkg::OUTSRC_HI_OFS) begin
            rdataQ <= outSrcQ[2*PP-1:PP];
        end else if (regAddr == pad_mux_pkg::IN_ROUTE_OFS) begin
            rdataQ <= inRouteQ;
        end else if (regAddr == pad_mux_pkg::FIXED_MASK_OFS) begin
            rdataQ <= {24'h0, pad_mux_pkg::FIXED_PAD_MASK};
        end else begin
            rdataQ <= '0;
        end
    end

    // Each multiplexed pad picks its driver from the mode code
    for (genvar g = 0; g < NP; g++) begin : gPad
        pad_route_cell route (
            .mode(funcSelQ[g]),
            .funcOut(periphPadOut[g*NF +: NF]),
            .funcOe(periphPadOe[g*NF +: NF]),
            .gpioData(padGpioDataQ[g]),
            .gpioDir(padGpioDirQ[g]),
            .outD(padOutD[g]),
            .oeD(padOeD[g])
        );
    end

    // Port pins: peripheral when in-use bit clear, else GPIO with special source
    always_comb begin
        for (int i = 0; i < PP; i++) begin
            portOutD[i] = portPeriphOut[i];
            portOeD[i] = portPeriphOe[i];
            if (inUseQ[i]) begin
                portOeD[i] = portDirQ[i];
                case (outSrcQ[2*i +: 2])
                    pad_mux_pkg::OUTSRC_A: portOutD[i] = portSigA[i];
                    pad_mux_pkg::OUTSRC_B: portOutD[i] = portSigB[i];
                    pad_mux_pkg::OUTSRC_C: portOutD[i] = portSigC[i];
                    default: portOutD[i] = portDataQ[i];
                endcase
            end
        end
    end

    // Registered pad drive keeps outputs glitch-free across mode changes
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            padOutQ <= '0;
            padOeQ <= '0;
            portOutQ <= '0;
            portOeQ <= '0;
        end else begin
            padOutQ <= padOutD;
            padOeQ <= padOeD;
            portOutQ <= portOutD;
            portOeQ <= portOeD;
        end
    end

    // Inward paths; loopback feeds the driven level back to the peripheral
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            periphPadInQ <= '0;
            muxedPortInQ <= 1'b0;
            portPeriphInQ <= '0;
            routeAQ <= '0;
            routeBQ <= '0;
        end else begin
            periphPadInQ <= (loopbackQ & padOutQ) | (~loopbackQ & padLevel);
            muxedPortInQ <= padLevel[inputSelQ];
            portPeriphInQ <= portLevel & ~inUseQ;
            routeAQ <= portLevel & inUseQ & ~inRouteQ;
            routeBQ <= portLevel & inUseQ & inRouteQ;
        end
    end

    // Electrical settings presented to the pad cells
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            slewQ <= '0;
            driveQ <= '0;
            pullQ <= '0;
            pullupOutQ <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                slewQ[i] <= padCfgQ[i][pad_mux_pkg::CFG_SLEW_BIT];
                driveQ[i*3 +: 3] <= padCfgQ[i][pad_mux_pkg::CFG_DRIVE_LSB +: 3];
                pullQ[i*2 +: 2] <= padCfgQ[i][pad_mux_pkg::CFG_PULL_LSB +: 2];
            end
            pullupOutQ <= pullupQ;
        end
    end

    assign regRdata = rdataQ;
    assign padOut = padOutQ;
    assign padOe = padOeQ;
    assign padSlew = slewQ;
    assign padDrive = driveQ;
    assign padPull = pullQ;
    assign periphPadIn = periphPadInQ;
    assign muxedPortIn = muxedPortInQ;
    assign portPadOut = portOutQ;
    assign portPadOe = portOeQ;
    assign portPullup = pullupOutQ;
    assign portPeriphIn = portPeriphInQ;
    assign portRouteA = routeAQ;
    assign portRouteB = routeBQ;

    chk_fixed_mode_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        regWr ##1 1'b1 |-> funcSelQ[0] == pad_mux_pkg::FIXED_PAD_MODE[MW-1:0])
        else $error("fixed pad mode changed");
    chk_reset_primary: assert property (@(posedge clk_sys)
        $fell(sys_rst) |-> funcSelQ[1] == pad_mux_pkg::MODE_PRIMARY)
        else $error("function select not primary after reset");
    chk_primary_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
        funcSelQ[1] == pad_mux_pkg::MODE_PRIMARY |=> padOut[1] == $past(periphPadOut[NF]))
        else $error("primary function not routed");
    chk_alt_three: assert property (@(posedge clk_sys) disable iff (sys_rst)
        funcSelQ[2] == pad_mux_pkg::MODE_ALT3 |=> padOe[2] == $past(periphPadOe[2*NF+3]))
        else $error("alternate mode 3 not routed");
    chk_gpio_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
        funcSelQ[3] == pad_mux_pkg::MODE_GPIO && padGpioDirQ[3]
        |=> padOe[3] && padOut[3] == $past(padGpioDataQ[3]))
        else $error("gpio pad not driven from data bit");
    chk_level_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
        regRd && regAddr == pad_mux_pkg::PAD_LEVEL_OFS
        |=> regRdata[NP-1:0] == $past(padLevel) ##1 regRdata == '0 || $past(regRd))
        else $error("pad level read wrong");
    chk_input_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
        1'b1 |=> muxedPortIn == $past(padLevel[inputSelQ]))
        else $error("input select wrong");

    chk_loopback_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
        loopbackQ[4] |=> periphPadIn[4] == $past(padOutQ[4]))
        else $error("loopback path wrong");

    chk_in_use_mux: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !inUseQ[0] |=> portPadOut[0] == $past(portPeriphOut[0]))
        else $error("in-use peripheral path wrong");

    chk_special_source: assert property (@(posedge clk_sys) disable iff (sys_rst)
        inUseQ[5] && outSrcQ[11:10] == pad_mux_pkg::OUTSRC_C
        |=> portPadOut[5] == $past(portSigC[5]))
        else $error("special output source wrong");

    chk_pullup_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
        regWr && regAddr == pad_mux_pkg::PULLUP_OFS |=> ##1 portPullup == $past(regWdata, 2))
        else $error("pull-up enable not presented");

    chk_slew_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
        1'b1 |=> padSlew[6] == $past(padCfgQ[6][pad_mux_pkg::CFG_SLEW_BIT]))
        else $error("slew setting not presented");

    cov_gpio_pad: cover property (@(posedge clk_sys) disable iff (sys_rst)
        funcSelQ[3] == pad_mux_pkg::MODE_GPIO ##1 padOe[3]);
    cov_loopback: cover property (@(posedge clk_sys) disable iff (sys_rst) loopbackQ[4]);
    cov_route_b: cover property (@(posedge clk_sys) disable iff (sys_rst) |portRouteB);
endmodule

// [pad_side_model.sv]
// Pads and board wiring seen from the far side of the multiplexer
module pad_side_model (
    // Pad drive from the block
    input wire logic [pad_mux_pkg::NUM_PADS-1:0] padOut,
    input wire logic [pad_mux_pkg::NUM_PADS-1:0] padOe,
    input wire logic [pad_mux_pkg::PORT_PINS-1:0] portPadOut,
    input wire logic [pad_mux_pkg::PORT_PINS-1:0] portPadOe,
    // Board levels on released pads
    input wire logic [pad_mux_pkg::NUM_PADS-1:0] extPad,
    input wire logic [pad_mux_pkg::PORT_PINS-1:0] extPort,
    // Resolved levels
    output logic [pad_mux_pkg::NUM_PADS-1:0] padIn,
    output logic [pad_mux_pkg::PORT_PINS-1:0] portPadIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pad shows the board level, never the last driven one
    assign padIn = (padOe & padOut) | (~padOe & extPad);
    assign portPadIn = (portPadOe & portPadOut) | (~portPadOe & extPort);
endmodule

// [pad_function_multiplexer_tb.sv]
// Self-checking bench for the pad function multiplexer
module pad_function_multiplexer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata, rv, gd, u, d, dir, rt, pu, lvv;
    logic [7:0] padIn, padOut, padOe, padSlew, periphPadIn, extPad = 8'h00, e;
    logic [23:0] padDrive;
    logic [15:0] padPull;
    logic [55:0] periphPadOut = '0, periphPadOe = '0, po, pe;
    logic muxedPortIn, eo, ee, lv;
    logic [31:0] portPadIn, portPadOut, portPadOe, portPullup, portPeriphIn, portRouteA;
    logic [31:0] portRouteB, extPort = '0, portPeriphOut = '0, portPeriphOe = '0;
    logic [31:0] portSigA = '0, portSigB = '0, portSigC = '0, seed = 32'h30;
    logic [63:0] sel;
    logic [1:0] src;
    int mismatches = 0;
    int checked = 0;
    int cfgModel[$];

    pad_function_multiplexer i_pad_function_multiplexer (.*);
    pad_side_model i_pad_side_model (.*);

    always #5 clk_sys = ~clk_sys;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        v = regRdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), rv);
            chk("sel", rv, 32'h0);
            rd(8'(32 + 4 * i), rv);
            chk("cfg", rv, 32'(pad_mux_pkg::PAD_CFG_RESET));
        end
        wr(8'h00, 32'h3);
        rd(8'h00, rv);
        chk("fixed sel", rv, 32'h0);
        rd(8'h70, rv);
        chk("fixed mask", rv, 32'(pad_mux_pkg::FIXED_PAD_MASK));
        rd(8'h74, rv);
        chk("unmapped", rv, 32'h0);
        // Every mode code on every free pad, loopback on
        for (int i = 1; i < 8; i++) begin
            for (int m = 0; m < 8; m++) begin
                po = 56'({rnd(), rnd()});
                pe = 56'({rnd(), rnd()});
                gd = rnd();
                @(posedge clk_sys);
                periphPadOut <= po;
                periphPadOe <= pe;
                // Output state set before the pad turns to GPIO
                wr(8'h44, gd);
                wr(8'h48, gd >> 8);
                wr(8'(4 * i), 32'(m) | 32'h10);
                settle(3);
                eo = m == 5 ? gd[i] : m == 7 ? 1'b0 : po[i * 7 + m];
                ee = m == 5 ? gd[8 + i] : m == 7 ? 1'b0 : pe[i * 7 + m];
                chk("padOut", padOut[i], eo);
                chk("padOe", padOe[i], ee);
                chk("loopback", periphPadIn[i], eo);
                chk("pad0", {padOe[0], padOut[0]}, {pe[0], po[0]});
            end
        end
        for (int i = 0; i < 8; i++) begin
            gd = rnd() & 32'h3f;
            wr(8'(32 + 4 * i), gd);
            rd(8'(32 + 4 * i), rv);
            chk("cfg rd", rv, gd);
            chk("cfg pad", {padPull[2 * i +: 2], padDrive[3 * i +: 3], padSlew[i]}, gd);
            cfgModel.push_back(int'(gd));
        end
        // Neighbouring pad settings must not alias each other
        for (int i = 0; i < 8; i++) begin
            rd(8'(32 + 4 * i), rv);
            chk("cfg hold", rv, 32'(cfgModel.pop_front()));
        end
        e = 8'(rnd());
        @(posedge clk_sys);
        periphPadOe <= '0;
        extPad <= e;
        for (int s = 0; s < 8; s++) begin
            wr(8'h40, s);
            settle(6);
            chk("muxIn", muxedPortIn, e[s]);
        end
        // Pad 7 carries an external interrupt: GPIO input, loopback off
        wr(8'h48, 32'h0);
        wr(8'h1c, 32'h5);
        settle(2);
        chk("irq pad oe", padOe[7], 1'b0);
        chk("pad in", {periphPadIn[7], periphPadIn[0]}, {e[7], e[0]});
        rd(8'h4c, rv);
        chk("pad level", rv, 32'(e));
        repeat (4) begin
            {u, pu, d, dir, rt} = {rnd(), rnd(), rnd(), rnd(), rnd()};
            sel = {rnd(), rnd()};
            @(posedge clk_sys);
            {portPeriphOut, portPeriphOe, portSigA} <= {rnd(), rnd(), rnd()};
            {portSigB, portSigC, extPort} <= {rnd(), rnd(), rnd()};
            wr(8'h50, u);
            wr(8'h54, pu);
            wr(8'h58, d);
            wr(8'h5c, dir);
            wr(8'h64, sel[31:0]);
            wr(8'h68, sel[63:32]);
            wr(8'h6c, rt);
            settle(6);
            chk("pullup", portPullup, pu);
            for (int p = 0; p < 32; p++) begin
                src = sel[2 * p +: 2];
                eo = !u[p] ? portPeriphOut[p] : src == 0 ? d[p]
                    : src == 1 ? portSigA[p] : src == 2 ? portSigB[p] : portSigC[p];
                ee = u[p] ? dir[p] : portPeriphOe[p];
                lv = ee ? eo : extPort[p];
                lvv[p] = lv;
                chk("port out", {portPadOe[p], portPadOut[p]}, {ee, eo});
                chk("periphIn", portPeriphIn[p], !u[p] & lv);
                chk("routeA", portRouteA[p], u[p] & !rt[p] & lv);
                chk("routeB", portRouteB[p], u[p] & rt[p] & lv);
            end
            rd(8'h60, rv);
            chk("port level", rv, lvv);
        end
        wrap_up();
    end
endmodule
